/* File: hw/asd_pkg.sv */
// Shared types and constants for the arithmetic, shift and branch execute block
package asd_pkg;
   // ----------------------------------------
   // Opcodes
   // ----------------------------------------
   localparam logic [7:0] OPC_STK_ADJ  = 8'ha7;
   localparam logic [7:0] OPC_IDX_ADJ  = 8'haf;
   localparam logic [7:0] OPC_BR_CC    = 8'h24;
   localparam logic [7:0] OPC_SHL_DIR  = 8'h38;
   localparam logic [7:0] OPC_SHL_A    = 8'h48;
   localparam logic [7:0] OPC_SHL_X    = 8'h58;
   localparam logic [7:0] OPC_SHL_PTR8 = 8'h68;
   localparam logic [7:0] OPC_SHL_PTR  = 8'h78;
   localparam logic [7:0] OPC_SHL_STK8 = 8'h68;
   localparam logic [7:0] OPC_SHR_A    = 8'h47;
   localparam logic [7:0] OPC_SHR_X    = 8'h57;
   localparam logic [3:0] LO_ADC       = 4'h9;
   localparam logic [3:0] LO_ADD       = 4'hb;
   localparam logic [3:0] LO_AND       = 4'h4;
   localparam logic [3:0] HI_LIT       = 4'ha;
   localparam logic [3:0] HI_DIR       = 4'hb;
   localparam logic [3:0] HI_LONG      = 4'hc;
   localparam logic [3:0] HI_PTR16     = 4'hd;
   localparam logic [3:0] HI_PTR8      = 4'he;
   localparam logic [3:0] HI_PTR       = 4'hf;
   // ----------------------------------------
   // Bus cycle counts
   // ----------------------------------------
   localparam logic [2:0] CYC_LIT = 3'h2, CYC_DIR = 3'h3, CYC_LONG = 3'h4, CYC_PTR16 = 3'h4;
   localparam logic [2:0] CYC_PTR8 = 3'h3, CYC_PTR = 3'h3, CYC_STK16 = 3'h5, CYC_STK8 = 3'h4;
   localparam logic [2:0] CYC_ADJ = 3'h2, CYC_BRANCH = 3'h3, CYC_NOP = 3'h1;
   localparam logic [2:0] CYC_SH_DIR = 3'h5, CYC_SH_PTR8 = 3'h5, CYC_SH_PTR = 3'h4, CYC_SH_STK8 = 3'h6;
   // Phase of the execute edge: memory operands arrive one edge later
   localparam logic [2:0] PH_EXEC_REG = 3'h1;
   localparam logic [2:0] PH_EXEC_MEM = 3'h2;
   // ----------------------------------------
   // Condition flag positions and reset values
   // ----------------------------------------
   localparam int FLG_V = 7, FLG_H = 4, FLG_I = 3, FLG_N = 2, FLG_Z = 1, FLG_C = 0;
   localparam logic [7:0]  RST_ACC = 8'h00, RST_FLAGS = 8'h00;
   localparam logic [15:0] RST_HX  = 16'h0000, RST_SP = 16'h0000;
   localparam logic [7:0]  DIR_PAGE = 8'h00;

   typedef enum logic [3:0] {
      M_ACC = 4'h0, M_XLO = 4'h1, M_LIT = 4'h2, M_DIR = 4'h3, M_LONG = 4'h4, M_PTR16 = 4'h5,
      M_PTR8 = 4'h6, M_PTR = 4'h7, M_STK16 = 4'h8, M_STK8 = 4'h9, M_REL = 4'ha, M_PTR_INC = 4'hb,
      M_PTR8_INC = 4'hc
   } asd_mode_t;
   typedef enum logic [3:0] {
      A_NONE = 4'h0, A_ADC = 4'h1, A_ADD = 4'h2, A_AND = 4'h3, A_SHL = 4'h4,
      A_SHR = 4'h5, A_STK_ADJ = 4'h6, A_IDX_ADJ = 4'h7, A_BR_CC = 4'h8
   } asd_alu_t;
   typedef struct packed {
      logic        pre;
      logic [7:0]  op;
      logic [7:0]  b1;
      logic [7:0]  b2;
      logic [15:0] next_pc;
   } asd_instr_t;
   typedef struct packed {
      asd_alu_t   alu;
      asd_mode_t  mode;
      logic [2:0] cyc;
      logic       rd;
   } asd_dec_t;
endpackage

/* File: hw/asd_exec.sv */
// Decode and execute of add, carry-add, AND, shifts, stack/index adjust and carry-clear branch
`timescale 1ns/1ps
// Contract
// - Plain pointer address is index pair
// - Post-increment pointer uses pair then increments
// - Short pointer adds unsigned byte offset
// - Long pointer adds high-first 16-bit offset
// - Relative mode takes one signed offset byte
// - Stack modes add offset to stack pointer
// - Carry-add: A plus operand plus carry
// - Plain add ignores carry, same flags
// - Stack adjust adds signed byte, 2 cycles
// - Index adjust adds signed byte, 2 cycles
// - AND clears V, sets N and Z
// - Left shift opcodes and cycle counts
// - Left shift flags V N Z C
// - Right shift opcodes 47, 57, one cycle
// - Carry-clear branch, 3 cycles, no flags
// - Flag bit positions V H I N Z C
// - Branch reach from next instruction address
// - Direct mode high address byte zero
module asd_exec (
   input  wire logic              MCLK_I,
   input  wire logic              RST_I,
   input  wire logic              INSTR_VALID_I,
   input  wire asd_pkg::asd_instr_t INSTR_I,
   input  wire logic [7:0]        MEM_RDATA_I,
   output logic                   RDY_O,
   output logic                   DONE_O,
   output logic                   ILLEGAL_O,
   output logic                   MEM_RD_O,
   output logic                   MEM_WR_O,
   output logic [15:0]            MEM_ADDR_O,
   output logic [7:0]             MEM_WDATA_O,
   output logic [7:0]             A_O,
   output logic [15:0]            HX_O,
   output logic [15:0]            SP_O,
   output logic [7:0]             FLAGS_O,
   output logic                   BR_TAKEN_O,
   output logic [15:0]            BR_TARGET_O
);
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function automatic asd_pkg::asd_dec_t decode(input logic pre, input logic [7:0] op);
      asd_pkg::asd_dec_t d;
      d = '{alu: asd_pkg::A_NONE, mode: asd_pkg::M_ACC, cyc: asd_pkg::CYC_NOP, rd: 1'b0};
      if (!pre) begin
         case (op)
            asd_pkg::OPC_STK_ADJ:  d = '{asd_pkg::A_STK_ADJ, asd_pkg::M_LIT, asd_pkg::CYC_ADJ, 1'b0};
            asd_pkg::OPC_IDX_ADJ:  d = '{asd_pkg::A_IDX_ADJ, asd_pkg::M_LIT, asd_pkg::CYC_ADJ, 1'b0};
            asd_pkg::OPC_BR_CC:    d = '{asd_pkg::A_BR_CC, asd_pkg::M_REL, asd_pkg::CYC_BRANCH, 1'b0};
            asd_pkg::OPC_SHL_DIR:  d = '{asd_pkg::A_SHL, asd_pkg::M_DIR, asd_pkg::CYC_SH_DIR, 1'b1};
            asd_pkg::OPC_SHL_A:    d = '{asd_pkg::A_SHL, asd_pkg::M_ACC, asd_pkg::CYC_NOP, 1'b0};
            asd_pkg::OPC_SHL_X:    d = '{asd_pkg::A_SHL, asd_pkg::M_XLO, asd_pkg::CYC_NOP, 1'b0};
            asd_pkg::OPC_SHL_PTR8: d = '{asd_pkg::A_SHL, asd_pkg::M_PTR8, asd_pkg::CYC_SH_PTR8, 1'b1};
            asd_pkg::OPC_SHL_PTR:  d = '{asd_pkg::A_SHL, asd_pkg::M_PTR, asd_pkg::CYC_SH_PTR, 1'b1};
            asd_pkg::OPC_SHR_A:    d = '{asd_pkg::A_SHR, asd_pkg::M_ACC, asd_pkg::CYC_NOP, 1'b0};
            asd_pkg::OPC_SHR_X:    d = '{asd_pkg::A_SHR, asd_pkg::M_XLO, asd_pkg::CYC_NOP, 1'b0};
            default: begin
               case (op[7:4])
                  asd_pkg::HI_LIT:   d = '{asd_pkg::A_NONE, asd_pkg::M_LIT, asd_pkg::CYC_LIT, 1'b0};
                  asd_pkg::HI_DIR:   d = '{asd_pkg::A_NONE, asd_pkg::M_DIR, asd_pkg::CYC_DIR, 1'b1};
                  asd_pkg::HI_LONG:  d = '{asd_pkg::A_NONE, asd_pkg::M_LONG, asd_pkg::CYC_LONG, 1'b1};
                  asd_pkg::HI_PTR16: d = '{asd_pkg::A_NONE, asd_pkg::M_PTR16, asd_pkg::CYC_PTR16, 1'b1};
                  asd_pkg::HI_PTR8:  d = '{asd_pkg::A_NONE, asd_pkg::M_PTR8, asd_pkg::CYC_PTR8, 1'b1};
                  asd_pkg::HI_PTR:   d = '{asd_pkg::A_NONE, asd_pkg::M_PTR, asd_pkg::CYC_PTR, 1'b1};
                  default:           d.cyc = asd_pkg::CYC_NOP;
               endcase
            end
         endcase
      end else if (op == asd_pkg::OPC_SHL_STK8) begin
         d = '{asd_pkg::A_SHL, asd_pkg::M_STK8, asd_pkg::CYC_SH_STK8, 1'b1};
      end else if (op[7:4] == asd_pkg::HI_PTR16) begin
         d = '{asd_pkg::A_NONE, asd_pkg::M_STK16, asd_pkg::CYC_STK16, 1'b1};
      end else if (op[7:4] == asd_pkg::HI_PTR8) begin
         d = '{asd_pkg::A_NONE, asd_pkg::M_STK8, asd_pkg::CYC_STK8, 1'b1};
      end
      // Arithmetic groups share the mode column; only the low nibble picks the operation
      if (d.alu == asd_pkg::A_NONE && d.mode != asd_pkg::M_ACC) begin
         case (op[3:0])
            asd_pkg::LO_ADC: d.alu = asd_pkg::A_ADC;
            asd_pkg::LO_ADD: d.alu = asd_pkg::A_ADD;
            asd_pkg::LO_AND: d.alu = asd_pkg::A_AND;
            default:         d = '{asd_pkg::A_NONE, asd_pkg::M_ACC, asd_pkg::CYC_NOP, 1'b0};
         endcase
      end
      return d;
   endfunction

   // ----------------------------------------
   // Effective address
   // ----------------------------------------
   function automatic logic [15:0] eff_addr(input asd_pkg::asd_mode_t m, input asd_pkg::asd_instr_t i,
                                            input logic [15:0] hx, input logic [15:0] sp);
      case (m)
         asd_pkg::M_DIR:  eff_addr = {asd_pkg::DIR_PAGE, i.b1};
         asd_pkg::M_LONG:     eff_addr = {i.b1, i.b2};
         asd_pkg::M_PTR16:    eff_addr = hx + {i.b1, i.b2};
         asd_pkg::M_PTR8,
         asd_pkg::M_PTR8_INC: eff_addr = hx + {8'h00, i.b1};
         asd_pkg::M_PTR,
         asd_pkg::M_PTR_INC:  eff_addr = hx;
         asd_pkg::M_STK16:    eff_addr = sp + {i.b1, i.b2};
         asd_pkg::M_STK8:     eff_addr = sp + {8'h00, i.b1};
         default:         eff_addr = 16'h0000;
      endcase
   endfunction

   // ----------------------------------------
   // Sequencing and execution
   // ----------------------------------------
   logic                busy, next_busy;
   logic [2:0]          ph, next_ph;
   asd_pkg::asd_instr_t ir, next_ir;
   asd_pkg::asd_dec_t   dec, next_dec;
   logic                next_rdy, next_done, next_ill, next_rd, next_wr, next_taken;
   logic [15:0]         next_addr, next_tgt, next_hx, next_sp;
   logic [7:0]          next_wdata, next_acc, next_flags;
   logic                accept;
   logic                exec_now;

   assign accept   = INSTR_VALID_I & RDY_O;
   assign exec_now = busy & (ph == (dec.rd ? asd_pkg::PH_EXEC_MEM : asd_pkg::PH_EXEC_REG));

   always_comb begin
      logic [7:0]  opnd;
      logic [7:0]  r;
      logic [8:0]  sum;
      logic        co;
      logic [15:0] sx;
      opnd = 8'h00;
      r    = 8'h00;
      sum  = 9'h000;
      co   = 1'b0;
      sx   = {{8{ir.b1[7]}}, ir.b1};
      next_busy = busy;  next_ph = ph;  next_ir = ir;  next_dec = dec;
      next_rdy = RDY_O;  next_done = 1'b0;  next_ill = ILLEGAL_O;
      next_rd = 1'b0;  next_wr = 1'b0;  next_addr = MEM_ADDR_O;  next_wdata = MEM_WDATA_O;
      next_acc = A_O;  next_hx = HX_O;  next_sp = SP_O;  next_flags = FLAGS_O;
      next_taken = BR_TAKEN_O;  next_tgt = BR_TARGET_O;
      if (accept) begin
         next_ir    = INSTR_I;
         next_dec   = decode(INSTR_I.pre, INSTR_I.op);
         next_busy  = 1'b1;
         next_ph    = 3'h1;
         next_rdy   = 1'b0;
         next_ill   = 1'b0;
         next_taken = 1'b0;
         next_rd    = next_dec.rd;
         next_addr  = eff_addr(next_dec.mode, INSTR_I, HX_O, SP_O);
      end else if (busy) begin
         next_ph = ph + 3'h1;
         if (exec_now) begin
            case (dec.mode)
               asd_pkg::M_ACC:   opnd = A_O;
               asd_pkg::M_XLO:   opnd = HX_O[7:0];
               default:          opnd = dec.rd ? MEM_RDATA_I : ir.b1;
            endcase
            // Carry in only for the carry-add form
            sum = {1'b0, A_O} + {1'b0, opnd} + {8'h00, (dec.alu == asd_pkg::A_ADC) & FLAGS_O[asd_pkg::FLG_C]};
            case (dec.alu)
               asd_pkg::A_ADC, asd_pkg::A_ADD: begin
                  r = sum[7:0];
                  next_acc = r;
                  next_flags[asd_pkg::FLG_V] = (A_O[7] & opnd[7] & ~r[7]) | (~A_O[7] & ~opnd[7] & r[7]);
                  next_flags[asd_pkg::FLG_H] = (A_O[3] & opnd[3]) | (opnd[3] & ~r[3]) | (~r[3] & A_O[3]);
                  next_flags[asd_pkg::FLG_N] = r[7];
                  next_flags[asd_pkg::FLG_Z] = (r == 8'h00);
                  next_flags[asd_pkg::FLG_C] = sum[8];
               end
               asd_pkg::A_AND: begin
                  r = A_O & opnd;
                  next_acc = r;
                  next_flags[asd_pkg::FLG_V] = 1'b0;
                  next_flags[asd_pkg::FLG_N] = r[7];
                  next_flags[asd_pkg::FLG_Z] = (r == 8'h00);
               end
               asd_pkg::A_SHL, asd_pkg::A_SHR: begin
                  if (dec.alu == asd_pkg::A_SHL) begin
                     r  = {opnd[6:0], 1'b0};
                     co = opnd[7];
                  end else begin
                     r  = {opnd[7], opnd[7:1]};
                     co = opnd[0];
                  end
                  // Half-carry is left alone by both shifts
                  next_flags[asd_pkg::FLG_V] = r[7] ^ co;
                  next_flags[asd_pkg::FLG_N] = r[7];
                  next_flags[asd_pkg::FLG_Z] = (r == 8'h00);
                  next_flags[asd_pkg::FLG_C] = co;
                  if (dec.mode == asd_pkg::M_ACC) begin
                     next_acc = r;
                  end else if (dec.mode == asd_pkg::M_XLO) begin
                     next_hx = {HX_O[15:8], r};
                  end else begin
                     next_wr    = 1'b1;
                     next_wdata = r;
                  end
               end
               asd_pkg::A_STK_ADJ: next_sp = SP_O + sx;
               asd_pkg::A_IDX_ADJ: next_hx = HX_O + sx;
               asd_pkg::A_BR_CC: begin
                  next_taken = ~FLAGS_O[asd_pkg::FLG_C];
                  next_tgt   = ir.next_pc + sx;
               end
               default: next_ill = 1'b1;
            endcase
            // Post-increment forms belong to compare-branch and copy; none decode here
            if (dec.mode == asd_pkg::M_PTR_INC || dec.mode == asd_pkg::M_PTR8_INC) begin
               next_hx = HX_O + 16'h0001;
            end
         end
         if (ph == dec.cyc) begin
            next_done = 1'b1;
            next_busy = 1'b0;
            next_rdy  = 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         busy <= 1'b0;  ph <= 3'h0;  ir <= '0;
         dec <= '{asd_pkg::A_NONE, asd_pkg::M_ACC, asd_pkg::CYC_NOP, 1'b0};
         RDY_O <= 1'b1;  DONE_O <= 1'b0;  ILLEGAL_O <= 1'b0;
         MEM_RD_O <= 1'b0;  MEM_WR_O <= 1'b0;  MEM_ADDR_O <= 16'h0000;  MEM_WDATA_O <= 8'h00;
         A_O <= asd_pkg::RST_ACC;  HX_O <= asd_pkg::RST_HX;  SP_O <= asd_pkg::RST_SP;
         FLAGS_O <= asd_pkg::RST_FLAGS;  BR_TAKEN_O <= 1'b0;  BR_TARGET_O <= 16'h0000;
      end else begin
         busy <= next_busy;  ph <= next_ph;  ir <= next_ir;  dec <= next_dec;
         RDY_O <= next_rdy;  DONE_O <= next_done;  ILLEGAL_O <= next_ill;
         MEM_RD_O <= next_rd;  MEM_WR_O <= next_wr;  MEM_ADDR_O <= next_addr;  MEM_WDATA_O <= next_wdata;
         A_O <= next_acc;  HX_O <= next_hx;  SP_O <= next_sp;
         FLAGS_O <= next_flags;  BR_TAKEN_O <= next_taken;  BR_TARGET_O <= next_tgt;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_read_pulse;
      MEM_RD_O ##1 !MEM_RD_O;
   endsequence
   sequence s_take(logic [7:0] o);
      accept && !INSTR_I.pre && INSTR_I.op == o;
   endsequence

   chk_dir_page_zero: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (s_take(8'hbb)) |-> ##1 (MEM_ADDR_O[15:8] == 8'h00) and s_read_pulse)
      else $error("direct address high byte not zero");
   chk_ais_sp_adjust: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_take(8'ha7) |-> ##3 DONE_O && SP_O == $past(SP_O, 3) + {{8{$past(INSTR_I.b1[7], 3)}}, $past(INSTR_I.b1, 3)})
      else $error("stack adjust wrong value or timing");
   chk_aix_flags_kept: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_take(8'haf) |-> ##1 !DONE_O ##2 DONE_O && FLAGS_O == $past(FLAGS_O, 3))
      else $error("index adjust touched flags or wrong timing");
   chk_bcc_branch: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_take(8'h24) |-> ##4 DONE_O && BR_TAKEN_O == !$past(FLAGS_O[0], 4) && FLAGS_O == $past(FLAGS_O, 4))
      else $error("carry-clear branch decision or timing wrong");
   chk_asl_acc_shift: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_take(8'h48) |-> ##2 DONE_O && A_O == ($past(A_O, 2) << 1) && FLAGS_O[4] == $past(FLAGS_O[4], 2))
      else $error("accumulator left shift wrong");
   chk_asr_sign_keep: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_take(8'h47) |-> ##2 DONE_O && A_O == 8'($signed($past(A_O, 2)) >>> 1) && FLAGS_O[0] == $past(A_O[0], 2))
      else $error("accumulator right shift wrong");
   chk_and_ovf_clear: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_take(8'ha4) |-> ##3 DONE_O && !FLAGS_O[7] && A_O == ($past(A_O, 3) & $past(INSTR_I.b1, 3)))
      else $error("AND result or overflow wrong");
   chk_add_imm_sum: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_take(8'hab) |-> ##3 DONE_O && A_O == 8'($past(A_O, 3) + $past(INSTR_I.b1, 3)))
      else $error("add result wrong");
   chk_asl_dir_cycles: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_take(8'h38) |-> ##3 MEM_WR_O ##1 !DONE_O ##2 DONE_O)
      else $error("direct left shift timing wrong");
endmodule

/* File: verif/asd_mem_model.sv */
// Behavioural memory answering the execute block's read and write pulses
`timescale 1ns/1ps
module asd_mem_model (
   input  wire logic        clk_i,
   input  wire logic        mem_rd_i,
   input  wire logic        mem_wr_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic [7:0]       rdata_o
);
   logic [7:0] mem [0:65535];

   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'hff;
      end
   end

   // Read data stands one cycle only; afterwards the line toggles so a late sample is caught
   always @(posedge clk_i) begin
      if (mem_wr_i) begin
         mem[addr_i] <= wdata_i;
      end
      if (mem_rd_i) begin
         rdata_o <= mem[addr_i];
      end else begin
         rdata_o <= ~rdata_o;
      end
   end
endmodule

/* File: verif/asd_exec_bench.sv */
// Self-checking bench for the arithmetic, shift and branch execute block
`timescale 1ns/1ps
module asd_exec_bench;
   logic                MCLK_I        = 1'b0;
   logic                RST_I         = 1'b1;
   logic                INSTR_VALID_I = 1'b0;
   asd_pkg::asd_instr_t INSTR_I       = '0;
   logic [7:0]          MEM_RDATA_I;
   logic                RDY_O, DONE_O, ILLEGAL_O, MEM_RD_O, MEM_WR_O, BR_TAKEN_O;
   logic [15:0]         MEM_ADDR_O, HX_O, SP_O, BR_TARGET_O;
   logic [7:0]          MEM_WDATA_O, A_O, FLAGS_O;
   int                  mismatches = 0;
   int                  compares   = 0;
   int                  cycles     = 0;

   always #2 MCLK_I = ~MCLK_I;

   asd_exec u_dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I),
      .MEM_RDATA_I(MEM_RDATA_I), .RDY_O(RDY_O), .DONE_O(DONE_O), .ILLEGAL_O(ILLEGAL_O), .MEM_RD_O(MEM_RD_O),
      .MEM_WR_O(MEM_WR_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O), .A_O(A_O), .HX_O(HX_O),
      .SP_O(SP_O), .FLAGS_O(FLAGS_O), .BR_TAKEN_O(BR_TAKEN_O), .BR_TARGET_O(BR_TARGET_O));
   asd_mem_model u_mem (.clk_i(MCLK_I), .mem_rd_i(MEM_RD_O), .mem_wr_i(MEM_WR_O), .addr_i(MEM_ADDR_O),
      .wdata_i(MEM_WDATA_O), .rdata_o(MEM_RDATA_I));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task end_of_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task af(input logic [7:0] a, input logic [7:0] f);
      chk("acc", {8'h00, a}, {8'h00, A_O});
      chk("flags", {8'h00, f}, {8'h00, FLAGS_O});
   endtask

   // Offers one instruction, then counts edges from accept to the done pulse
   task automatic run(input logic pre, input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                      input logic [15:0] npc, input logic [2:0] cyc);
      int n;
      n = 0;
      @(posedge MCLK_I);
      INSTR_VALID_I <= 1'b1;
      INSTR_I       <= {pre, op, b1, b2, npc};
      @(posedge MCLK_I);
      INSTR_VALID_I <= 1'b0;
      do begin
         @(posedge MCLK_I);
         #1;
         n++;
      end while (DONE_O !== 1'b1 && n < 8);
      chk("cycles", {13'h0000, cyc}, n[15:0]);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      repeat (8) @(posedge MCLK_I);
      chk("ready", 16'h0001, {15'h0000, RDY_O});
      RST_I <= 1'b0;
      #1;
      af(8'h00, 8'h00);
   endtask

   task t_add;
      logic [7:0] op_t [8] = '{8'hab, 8'hab, 8'hab, 8'ha9, 8'hab, 8'hab, 8'hab, 8'hab};
      logic [7:0] b1_t [8] = '{8'h7f, 8'h01, 8'h80, 8'h05, 8'hff, 8'h01, 8'h82, 8'h88};
      logic [7:0] a_t  [8] = '{8'h7f, 8'h80, 8'h00, 8'h06, 8'h05, 8'h06, 8'h88, 8'h10};
      logic [7:0] f_t  [8] = '{8'h00, 8'h94, 8'h83, 8'h00, 8'h11, 8'h00, 8'h04, 8'h91};
      for (int i = 0; i < 8; i++) begin
         run(1'b0, op_t[i], b1_t[i], 8'h00, 16'h0000, 3'h2);
         af(a_t[i], f_t[i]);
      end
   endtask

   task t_adjust;
      run(1'b0, 8'haf, 8'hff, 8'h00, 16'h0000, 3'h2);
      chk("hx", 16'hffff, HX_O);
      run(1'b0, 8'ha7, 8'h80, 8'h00, 16'h0000, 3'h2);
      chk("sp", 16'hff80, SP_O);
      chk("flags", 16'h0091, {8'h00, FLAGS_O});
   endtask

   // Index pair is ffff and stack pointer ff80 here, so offsets wrap
   task t_and;
      logic        pr_t [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
      logic [7:0]  op_t [8] = '{8'ha4, 8'hb4, 8'hc4, 8'hd4, 8'he4, 8'hf4, 8'hd4, 8'he4};
      logic [7:0]  b1_t [8] = '{8'hff, 8'h42, 8'h12, 8'h01, 8'h80, 8'h00, 8'h00, 8'h90};
      logic [7:0]  b2_t [8] = '{8'h00, 8'h00, 8'h34, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
      logic [15:0] ad_t [8] = '{16'h0000, 16'h0042, 16'h1234, 16'h00ff, 16'h007f, 16'hffff, 16'hff90, 16'h0010};
      logic [2:0]  cy_t [8] = '{3'h2, 3'h3, 3'h4, 3'h4, 3'h3, 3'h3, 3'h5, 3'h4};
      for (int i = 0; i < 8; i++) begin
         run(pr_t[i], op_t[i], b1_t[i], b2_t[i], 16'h0000, cy_t[i]);
         if (i > 0) begin
            chk("addr", ad_t[i], MEM_ADDR_O);
         end
         af(8'h10, 8'h11);
      end
      u_mem.mem[16'h0043] = 8'h0f;
      run(1'b0, 8'hb4, 8'h43, 8'h00, 16'h0000, 3'h3);
      af(8'h00, 8'h13);
   endtask

   task t_shift;
      u_mem.mem[16'h0050] = 8'hc0;
      u_mem.mem[16'h0000] = 8'h01;
      u_mem.mem[16'h0010] = 8'h20;
      run(1'b0, 8'hab, 8'hc1, 8'h00, 16'h0000, 3'h2);
      run(1'b0, 8'h48, 8'h00, 8'h00, 16'h0000, 3'h1);
      af(8'h82, 8'h05);
      run(1'b0, 8'h47, 8'h00, 8'h00, 16'h0000, 3'h1);
      af(8'hc1, 8'h84);
      run(1'b0, 8'h58, 8'h00, 8'h00, 16'h0000, 3'h1);
      chk("hx", 16'hfffe, HX_O);
      run(1'b0, 8'h57, 8'h00, 8'h00, 16'h0000, 3'h1);
      chk("hx", 16'hffff, HX_O);
      run(1'b0, 8'h38, 8'h50, 8'h00, 16'h0000, 3'h5);
      chk("mem", 16'h0080, {8'h00, u_mem.mem[16'h0050]});
      run(1'b0, 8'h68, 8'h01, 8'h00, 16'h0000, 3'h5);
      chk("mem", 16'h0002, {8'h00, u_mem.mem[16'h0000]});
      run(1'b0, 8'h78, 8'h00, 8'h00, 16'h0000, 3'h4);
      chk("mem", 16'h00fe, {8'h00, u_mem.mem[16'hffff]});
      run(1'b1, 8'h68, 8'h90, 8'h00, 16'h0000, 3'h6);
      chk("mem", 16'h0040, {8'h00, u_mem.mem[16'h0010]});
      af(8'hc1, 8'h00);
   endtask

   task t_branch;
      run(1'b0, 8'h24, 8'h80, 8'h00, 16'h2000, 3'h3);
      chk("taken", 16'h0001, {15'h0000, BR_TAKEN_O});
      chk("target", 16'h1f80, BR_TARGET_O);
      run(1'b0, 8'h24, 8'h7f, 8'h00, 16'h2000, 3'h3);
      chk("target", 16'h207f, BR_TARGET_O);
      af(8'hc1, 8'h00);
      run(1'b0, 8'hab, 8'hc1, 8'h00, 16'h0000, 3'h2);
      run(1'b0, 8'h24, 8'h10, 8'h00, 16'h2000, 3'h3);
      chk("taken", 16'h0000, {15'h0000, BR_TAKEN_O});
      af(8'h82, 8'h05);
   endtask

   // Undecoded opcode: one cycle, no state change, flag cleared by the next accept
   task t_illegal;
      run(1'b0, 8'h37, 8'h00, 8'h00, 16'h0000, 3'h1);
      chk("illegal", 16'h0001, {15'h0000, ILLEGAL_O});
      af(8'h82, 8'h05);
      run(1'b0, 8'hab, 8'h00, 8'h00, 16'h0000, 3'h2);
      chk("illegal", 16'h0000, {15'h0000, ILLEGAL_O});
      af(8'h82, 8'h04);
   endtask

   always @(posedge MCLK_I) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         $display("BAD timeout expected done seen hang");
         end_of_test();
      end
   end

   initial begin
      t_reset();
      t_add();
      t_adjust();
      t_and();
      t_shift();
      t_branch();
      t_illegal();
      end_of_test();
   end
endmodule
